// ===== rtl/dfc_command_regs.v
// Contract
// - Only fieldbus module writes speed reference
// - Speed reference applied only when fieldbus selected
// - Speed signed, 2000h equals synchronous speed
// - Direction from sign and control bit two
// - Bits zero to four drive relays
// - Relay follows bit only when selected
// - Keypad cannot write digital output word
// - Four analog words, used when selected
// - Analog 0000h zero, 7FFFh full scale
// - Bipolar maps full signed range linearly
// - Keypad cannot write analog value words
// - Read-only module type code zero to 25
// - Codes 16-23 and 25 mean active module
// - Link status codes zero to four reported
`timescale 1ns/100ps
`include "dfc_regs.vh"

module dfc_command_regs (
  // Clock and reset
  input wire sys_clk_i,
  input wire reset_i,
  // Parameter access port
  input wire acc_wr_i,
  input wire acc_rd_i,
  input wire [9:0] acc_idx_i,
  input wire [15:0] acc_wdata_i,
  input wire [1:0] acc_src_i,
  output wire [15:0] acc_rdata_o,
  output wire acc_ack_o,
  output wire acc_err_o,
  // Drive configuration and state
  input wire [15:0] fieldbus_control_word_i,
  input wire ref_src_fieldbus_i,
  input wire [4:0] relay_follow_i,
  input wire [4:0] relay_other_i,
  input wire [11:0] ao_func_sel_i,
  input wire [3:0] ao_bipolar_i,
  input wire [63:0] ao_other_i,
  input wire [4:0] module_type_code_i,
  input wire [2:0] link_status_code_i,
  // Motor reference
  output wire speed_ref_valid_o,
  output wire [15:0] speed_mag_o,
  output wire dir_forward_o,
  // Outputs
  output wire [4:0] relay_out_o,
  output wire [63:0] ao_level_o
);

  ////////////////////////////////////////////////////////////////////////
  // Register index decode, shared by read and write paths
  function [7:0] idx_dec;
    input [9:0] idx;
    begin
      idx_dec = 8'h00;
      case (idx)
        `DFC_IDX_SPEED_REF: idx_dec = 8'h01;
        `DFC_IDX_DO_SET: idx_dec = 8'h02;
        `DFC_IDX_AO_ONE: idx_dec = 8'h04;
        `DFC_IDX_AO_TWO: idx_dec = 8'h08;
        `DFC_IDX_AO_THREE: idx_dec = 8'h10;
        `DFC_IDX_AO_FOUR: idx_dec = 8'h20;
        `DFC_IDX_MOD_TYPE: idx_dec = 8'h40;
        `DFC_IDX_LINK_STAT: idx_dec = 8'h80;
        default: idx_dec = 8'h00;
      endcase
    end
  endfunction

  wire [7:0] sel = idx_dec(acc_idx_i);

  ////////////////////////////////////////////////////////////////////////
  // Write permission by access source; reads are open to every source
  reg may_wr_speed;
  reg may_wr_net;
  always @* begin
    may_wr_speed = 1'b0;
    may_wr_net = 1'b0;
    case (acc_src_i)
      `DFC_SRC_FIELDBUS: begin
        may_wr_speed = 1'b1;
        may_wr_net = 1'b1;
      end
      `DFC_SRC_NETWORK: begin
        may_wr_speed = 1'b0;
        may_wr_net = 1'b1;
      end
      default: begin
        // Keypad and the spare code may only read
        may_wr_speed = 1'b0;
        may_wr_net = 1'b0;
      end
    endcase
  end

  wire wr_speed = acc_wr_i && sel[0] && may_wr_speed;
  wire wr_do = acc_wr_i && sel[1] && may_wr_net;
  wire [3:0] wr_ao = {4{acc_wr_i && may_wr_net}} & sel[5:2];

  // Anything not accepted is refused: bad source, read-only or unmapped
  wire wr_ok = wr_speed || wr_do || (|wr_ao);
  wire rd_ok = acc_rd_i && (|sel);

  ////////////////////////////////////////////////////////////////////////
  // Stored words
  reg [15:0] speed_ref_ff;
  reg [15:0] do_set_ff;
  reg [63:0] ao_val_ff;

  always @(posedge sys_clk_i) begin
    if (reset_i) begin
      speed_ref_ff <= `DFC_RST_SPEED_REF;
      do_set_ff <= `DFC_RST_DO_SET;
    end else begin
      if (wr_speed) begin
        speed_ref_ff <= acc_wdata_i;
      end
      if (wr_do) begin
        do_set_ff <= acc_wdata_i & `DFC_DO_MASK;
      end
    end
  end

  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_ao_store
      always @(posedge sys_clk_i) begin
        if (reset_i) begin
          ao_val_ff[16*g+15:16*g] <= `DFC_RST_AO;
        end else if (wr_ao[g]) begin
          ao_val_ff[16*g+15:16*g] <= acc_wdata_i;
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // Read mux and access answer
  reg [15:0] nxt_rdata;
  always @* begin
    nxt_rdata = 16'h0000;
    case (1'b1)
      sel[0]: nxt_rdata = speed_ref_ff;
      sel[1]: nxt_rdata = do_set_ff;
      sel[2]: nxt_rdata = ao_val_ff[15:0];
      sel[3]: nxt_rdata = ao_val_ff[31:16];
      sel[4]: nxt_rdata = ao_val_ff[47:32];
      sel[5]: nxt_rdata = ao_val_ff[63:48];
      sel[6]: nxt_rdata = {11'h000, module_type_code_i};
      sel[7]: nxt_rdata = {13'h0000, link_status_code_i};
      default: nxt_rdata = 16'h0000;
    endcase
  end

  // Refusal: wrong source, read-only word or unmapped index
  reg nxt_err;
  always @* begin
    nxt_err = 1'b0;
    if (acc_wr_i && !wr_ok) begin
      nxt_err = 1'b1;
    end
    if (acc_rd_i && !rd_ok) begin
      nxt_err = 1'b1;
    end
  end

  reg [15:0] rdata_ff;
  reg ack_ff;
  reg err_ff;
  always @(posedge sys_clk_i) begin
    if (reset_i) begin
      rdata_ff <= 16'h0000;
      ack_ff <= 1'b0;
      err_ff <= 1'b0;
    end else begin
      ack_ff <= acc_wr_i || acc_rd_i;
      err_ff <= nxt_err;
      if (acc_rd_i) begin
        rdata_ff <= rd_ok ? nxt_rdata : 16'h0000;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Speed reference to the motor
  wire ref_neg = speed_ref_ff[15];
  reg [15:0] ref_abs;
  always @* begin
    ref_abs = speed_ref_ff;
    if (ref_neg) begin
      // 8000h has no positive twin and stays 8000h
      ref_abs = ~speed_ref_ff + 16'h0001;
    end
  end

  reg nxt_dir_fwd;
  always @* begin
    nxt_dir_fwd = 1'b1;
    case ({fieldbus_control_word_i[`DFC_CTRL_DIR_BIT], ref_neg})
      2'h2: nxt_dir_fwd = 1'b1;
      2'h3: nxt_dir_fwd = 1'b0;
      2'h0: nxt_dir_fwd = 1'b0;
      2'h1: nxt_dir_fwd = 1'b1;
      default: nxt_dir_fwd = 1'b1;
    endcase
  end

  reg ref_valid_ff;
  reg [15:0] speed_mag_ff;
  reg dir_fwd_ff;
  always @(posedge sys_clk_i) begin
    if (reset_i) begin
      ref_valid_ff <= 1'b0;
      speed_mag_ff <= 16'h0000;
      dir_fwd_ff <= 1'b1;
    end else begin
      ref_valid_ff <= ref_src_fieldbus_i;
      speed_mag_ff <= ref_src_fieldbus_i ? ref_abs : 16'h0000;
      // Direction is kept live even while the reference is not selected
      dir_fwd_ff <= nxt_dir_fwd;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Relay outputs
  // One flip-flop per relay so each follows its own function selection
  reg [4:0] relay_ff;
  generate
    for (g = 0; g < `DFC_DO_BITS; g = g + 1) begin : g_relay
      always @(posedge sys_clk_i) begin
        if (reset_i) begin
          relay_ff[g] <= 1'b0;
        end else if (relay_follow_i[g]) begin
          // one bit per relay, 1 closes
          relay_ff[g] <= do_set_ff[g];
        end else begin
          relay_ff[g] <= relay_other_i[g];
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // Analog outputs: level is unsigned, offset-binary only when bipolar, 0000h bottom of span
  // Analog function select: codes one to four name a value word
  function ao_sel_is_word;
    input [2:0] fsel;
    begin
      ao_sel_is_word = (fsel >= `DFC_AO_SEL_ONE) &&
                       (fsel <= `DFC_AO_SEL_FOUR);
    end
  endfunction

  reg [63:0] ao_level_ff;
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_ao_out
      wire [2:0] fsel = ao_func_sel_i[3*g+2:3*g];
      wire [1:0] widx = fsel[1:0] - 2'h1;
      wire use_word = ao_sel_is_word(fsel);
      wire [15:0] word = ao_val_ff[16*widx +: 16];
      // 7FFFh is full, negatives clamp low
      reg [15:0] uni;
      always @* begin
        uni = 16'h0000;
        if (word[15]) begin
          // Negative codes have no place on a one-sided span
          uni = 16'h0000;
        end else begin
          // Repeat the top bit so that 7FFFh reaches FFFFh
          uni = {word[14:0], word[14]};
        end
      end
      wire [15:0] bip = word ^ 16'h8000;
      always @(posedge sys_clk_i) begin
        if (reset_i) begin
          ao_level_ff[16*g+15:16*g] <= 16'h0000;
        end else if (use_word) begin
          ao_level_ff[16*g+15:16*g] <= ao_bipolar_i[g] ? bip : uni;
        end else begin
          ao_level_ff[16*g+15:16*g] <= ao_other_i[16*g+15:16*g];
        end
      end
    end
  endgenerate

  assign acc_rdata_o = rdata_ff;
  assign acc_ack_o = ack_ff;
  assign acc_err_o = err_ff;
  assign speed_ref_valid_o = ref_valid_ff;
  assign speed_mag_o = speed_mag_ff;
  assign dir_forward_o = dir_fwd_ff;
  assign relay_out_o = relay_ff;
  assign ao_level_o = ao_level_ff;

endmodule // dfc_command_regs

// ===== rtl/dfc_regs.vh
`ifndef DFC_REGS_VH
`define DFC_REGS_VH

// Parameter numbers used as register index on the access port
`define DFC_IDX_SPEED_REF 10'h2AF
`define DFC_IDX_DO_SET 10'h2B7
`define DFC_IDX_AO_ONE 10'h2B8
`define DFC_IDX_AO_TWO 10'h2B9
`define DFC_IDX_AO_THREE 10'h2BA
`define DFC_IDX_AO_FOUR 10'h2BB
`define DFC_IDX_MOD_TYPE 10'h2D3
`define DFC_IDX_LINK_STAT 10'h2D4

// Access sources
`define DFC_SRC_KEYPAD 2'h0
`define DFC_SRC_FIELDBUS 2'h1
`define DFC_SRC_NETWORK 2'h2

// Field layout
`define DFC_DO_BITS 5
`define DFC_DO_MASK 16'h001F
`define DFC_CTRL_DIR_BIT 2

// Reset values
`define DFC_RST_SPEED_REF 16'h0000
`define DFC_RST_DO_SET 16'h0000
`define DFC_RST_AO 16'h0000

// Scales
`define DFC_SYNC_SPEED 16'h2000
`define DFC_AO_FULL 16'h7FFF

// Analog output function select codes
`define DFC_AO_SEL_OTHER 3'h0
`define DFC_AO_SEL_ONE 3'h1
`define DFC_AO_SEL_FOUR 3'h4

// Link status codes
`define DFC_LINK_ABSENT 3'h0
`define DFC_LINK_UNSUPPORTED 3'h1
`define DFC_LINK_ACCESS_ERR 3'h2
`define DFC_LINK_OFFLINE 3'h3
`define DFC_LINK_ONLINE 3'h4

`endif

// ===== verification/dfc_command_regs_checker.sv
`timescale 1ns/100ps
module dfc_checker (
  // Clock and access port
  input wire sys_clk_i,
  input wire reset_i,
  input wire acc_wr_i,
  input wire acc_rd_i,
  input wire [9:0] acc_idx_i,
  input wire [1:0] acc_src_i,
  input wire acc_ack_o,
  input wire acc_err_o,
  // Drive side
  input wire ref_src_fieldbus_i,
  input wire [4:0] relay_follow_i,
  input wire [4:0] relay_other_i,
  input wire speed_ref_valid_o,
  input wire [15:0] speed_mag_o,
  input wire [4:0] relay_out_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (reset_i);
  ////////////////////////////////////////
  a_ack_one_cycle: assert property (
    (acc_wr_i || acc_rd_i) |=> acc_ack_o) else $error("ack missing");
  a_ack_no_req: assert property (
    !(acc_wr_i || acc_rd_i) |=> !acc_ack_o)
    else $error("ack without request");
  a_keypad_refused: assert property (
    acc_wr_i && acc_src_i == 2'h0 |=> acc_err_o)
    else $error("keypad write taken");
  a_speed_src_only: assert property (
    acc_wr_i && acc_idx_i == 10'h2AF && acc_src_i != 2'h1 |=> acc_err_o)
    else $error("speed write taken");
  a_ro_refused: assert property (
    acc_wr_i && (acc_idx_i == 10'h2D3 || acc_idx_i == 10'h2D4)
    |=> acc_err_o) else $error("ro write taken");
  a_unsel_zero: assert property (
    !ref_src_fieldbus_i |=> speed_mag_o == 16'h0000)
    else $error("speed applied unselected");
  a_valid_lag: assert property (
    1 |=> speed_ref_valid_o == $past(ref_src_fieldbus_i))
    else $error("valid lag wrong");
  a_relay_other: assert property (
    !relay_follow_i[0] |=> relay_out_o[0] == $past(relay_other_i[0]))
    else $error("relay wrong");
  c_wr: cover property (acc_wr_i && acc_src_i == 2'h1);
  c_key: cover property (acc_wr_i && acc_src_i == 2'h0);
  c_follow: cover property (relay_follow_i[0] && relay_out_o[0]);
endmodule // dfc_checker

bind dfc_command_regs dfc_checker chk (.sys_clk_i(sys_clk_i),
  .reset_i(reset_i),
  .acc_wr_i(acc_wr_i), .acc_rd_i(acc_rd_i), .acc_idx_i(acc_idx_i),
  .acc_src_i(acc_src_i), .acc_ack_o(acc_ack_o), .acc_err_o(acc_err_o),
  .ref_src_fieldbus_i(ref_src_fieldbus_i), .relay_follow_i(relay_follow_i),
  .relay_other_i(relay_other_i), .speed_ref_valid_o(speed_ref_valid_o),
  .speed_mag_o(speed_mag_o), .relay_out_o(relay_out_o));

// ===== verification/dfc_module_model.sv
`timescale 1ns/100ps
module dfc_module_model #(
  // Arbitrary code for an active fieldbus module
  parameter [4:0] MOD_TYPE = 5'h11
) (
  // Clock
  input wire sys_clk_i,
  // Read-only views
  output logic [4:0] module_type_code_o,
  output logic [2:0] link_status_code_o
);
  assign module_type_code_o = MOD_TYPE;
  initial link_status_code_o = 3'h3;
  always @(posedge sys_clk_i) begin
    link_status_code_o <= 3'h4;
  end
endmodule // dfc_module_model

// ===== verification/tb.sv
`timescale 1ns/100ps
module tb;
  logic sys_clk_i = 0, reset_i = 1, wr = 0, rd = 0, rsel = 0;
  logic [9:0] idx = 0;
  logic [15:0] wd = 0, ctrl = 0, rdata, mag;
  logic [1:0] src = 0;
  logic [4:0] fol = 0, oth = 0, relay, mtype;
  logic [11:0] asel = 0;
  logic [3:0] bip = 0;
  logic [2:0] link;
  logic [63:0] lvl, aoo = 64'hABCD_1234_0000_0000;
  logic ack, err, valid, fwd;
  int fail_count = 0, compares = 0;
  // Rows: index, source, write data, refused, read back
  logic [44:0] rows [0:11] = '{
    {10'h2AF, 2'h1, 16'h1234, 1'b0, 16'h1234},
    {10'h2AF, 2'h0, 16'h0001, 1'b1, 16'h1234},
    {10'h2AF, 2'h2, 16'h0002, 1'b1, 16'h1234},
    {10'h2B7, 2'h1, 16'hFFFF, 1'b0, 16'h001F},
    {10'h2B7, 2'h0, 16'h0000, 1'b1, 16'h001F},
    {10'h2B8, 2'h2, 16'h7FFF, 1'b0, 16'h7FFF},
    {10'h2B9, 2'h0, 16'h0001, 1'b1, 16'h0000},
    {10'h2BA, 2'h1, 16'h8000, 1'b0, 16'h8000},
    {10'h2BB, 2'h2, 16'h0001, 1'b0, 16'h0001},
    {10'h2D3, 2'h1, 16'h0005, 1'b1, 16'h0011},
    {10'h2D4, 2'h1, 16'h0001, 1'b1, 16'h0004},
    {10'h3FF, 2'h1, 16'h0001, 1'b1, 16'h0000}};
  always #2 sys_clk_i = ~sys_clk_i;
  dfc_module_model part (.sys_clk_i(sys_clk_i),
    .module_type_code_o(mtype), .link_status_code_o(link));
  dfc_command_regs dut (.sys_clk_i(sys_clk_i), .reset_i(reset_i),
    .acc_wr_i(wr), .acc_rd_i(rd), .acc_idx_i(idx), .acc_wdata_i(wd),
    .acc_src_i(src), .acc_rdata_o(rdata), .acc_ack_o(ack),
    .acc_err_o(err), .fieldbus_control_word_i(ctrl),
    .ref_src_fieldbus_i(rsel), .relay_follow_i(fol),
    .relay_other_i(oth), .ao_func_sel_i(asel), .ao_bipolar_i(bip),
    .ao_other_i(aoo), .module_type_code_i(mtype),
    .link_status_code_i(link), .speed_ref_valid_o(valid),
    .speed_mag_o(mag), .dir_forward_o(fwd), .relay_out_o(relay),
    .ao_level_o(lvl));
  ////////////////////////////////////////
  task chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task end_sim;
    if (fail_count == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // Request held until the edge that samples it; answer read just after
  task acc(input logic w, input logic [9:0] i, input logic [1:0] s,
    input logic [15:0] d);
    @(posedge sys_clk_i);
    wr <= w;
    rd <= !w;
    idx <= i;
    src <= s;
    wd <= d;
    @(posedge sys_clk_i);
    wr <= 0;
    rd <= 0;
    #1;
  endtask
  ////////////////////////////////////////
  initial begin
    #4000;
    fail_count++;
    end_sim;
  end
  initial begin
    repeat (5) @(posedge sys_clk_i);
    reset_i <= 0;
    #1;
    chk(relay, 5'h00);
    chk(fwd, 1'b1);
    foreach (rows[i]) begin
      acc(1, rows[i][44:35], rows[i][34:33], rows[i][32:17]);
      chk(err, rows[i][16]);
      chk(ack, 1'b1);
      acc(0, rows[i][44:35], 2'h0, 16'h0);
      chk(rdata, rows[i][15:0]);
      chk(ack, 1'b1);
    end
    @(posedge sys_clk_i);
    fol <= 5'h15;
    oth <= 5'h02;
    rsel <= 1;
    ctrl <= 16'h0004;
    asel <= 12'h019;
    bip <= 4'h2;
    acc(1, 10'h2AF, 2'h1, 16'hE000);
    repeat (2) @(posedge sys_clk_i);
    #1;
    chk(mag, 16'h2000);
    chk(fwd, 1'b0);
    chk(relay, 5'h17);
    chk(valid, 1'b1);
    chk(lvl[15:0], 16'hFFFF);
    chk(lvl[31:16], 16'h0000);
    chk(lvl[47:32], 16'h1234);
    chk(lvl[63:48], 16'hABCD);
    @(posedge sys_clk_i);
    ctrl <= 16'h0000;
    rsel <= 0;
    repeat (2) @(posedge sys_clk_i);
    #1;
    chk(fwd, 1'b1);
    chk(mag, 16'h0000);
    chk(valid, 1'b0);
    end_sim;
  end
endmodule // tb
